/* File: logic/fswc_controller.sv */
// flash self-write controller: apb registers, unlock, erase/program
// assumes the flash array answers a read on the cycle after the request
`timescale 1ns/1ps
`default_nettype none
`include "fswc_defs.svh"

module fswc_controller
    import fswc_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES = `FSWC_ERASE_TIME_US * `FSWC_CLK_MHZ,
    parameter int unsigned PROG_CYCLES = `FSWC_PROG_TIME_US * `FSWC_CLK_MHZ,
    parameter int unsigned ROW_WORDS = 32
)(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic dev_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [15:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic write_protect_in,
    input wire logic [13:0] flash_rdata_in,
    output fswc_flash_req_s flash_req_out,
    output logic busy_out
);
    logic [14:0] addr, next_addr;
    logic [13:0] data, next_data;
    logic region, next_region, latch_only, next_latch_only, erase_req, next_erase_req;
    logic wr_err, next_wr_err, program_enable, next_program_enable, wr_bit, next_wr_bit;
    logic rd_bit, next_rd_bit, done_flag, next_done_flag;
    fswc_unlock_e unlock_st, next_unlock_st;
    fswc_state_e state, next_state;
    logic [23:0] cnt, next_cnt;
    logic [4:0] word_idx, next_word_idx;
    fswc_flash_req_s next_req;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic latch_load, latch_blank;
    logic [13:0] latch_word;
    logic acc_wr, acc_rd, setup, hit_addr, hit_data, hit_ctrl, hit_key;
    logic hit_stat, hit_any, start_try, start_ok, prot, err_set;

    function automatic logic in_rng(input logic [14:0] a, lo, hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction : in_rng

    function automatic logic aux_readable(input logic [14:0] a);
        aux_readable = in_rng(a, `FSWC_UID_LO, `FSWC_UID_HI) ||
                       in_rng(a, `FSWC_DID_LO, `FSWC_CFG_HI) ||
                       in_rng(a, `FSWC_DIA_LO, `FSWC_DIA_HI);
    endfunction : aux_readable

    function automatic logic aux_writable(input logic [14:0] a);
        aux_writable = in_rng(a, `FSWC_UID_LO, `FSWC_UID_HI) ||
                       in_rng(a, `FSWC_CFG_LO, `FSWC_CFG_HI);
    endfunction : aux_writable

    function automatic logic hit(input logic [15:0] pa, input logic [13:0] idx);
        hit = (pa[15:2] == idx) && (pa[1:0] == 2'b00);
    endfunction : hit

    assign setup = psel_in && !penable_in;
    assign acc_wr = psel_in && penable_in && pwrite_in;
    assign acc_rd = psel_in && penable_in && !pwrite_in;
    assign hit_addr = hit(paddr_in, `FSWC_IDX_ADDR);
    assign hit_data = hit(paddr_in, `FSWC_IDX_DATA);
    assign hit_ctrl = hit(paddr_in, `FSWC_IDX_CTRL);
    assign hit_key = hit(paddr_in, `FSWC_IDX_KEY);
    assign hit_stat = hit(paddr_in, `FSWC_IDX_STAT);
    assign hit_any = hit_addr || hit_data || hit_ctrl || hit_key || hit_stat;
    assign pready_out = 1'b1;
    assign busy_out = wr_bit;

    // a write start only counts while the unlock pair is armed
    assign start_try = acc_wr && hit_ctrl && pwdata_in[`FSWC_CTRL_WR];
    assign start_ok = start_try && unlock_st == UNL_AA && state == ST_IDLE;
    assign prot = pwdata_in[`FSWC_CTRL_REGS] ? !aux_writable(addr)
                                            : write_protect_in;

    fswc_latch_bank #(
        .WORDS(ROW_WORDS),
        .IDX_W(5)
    ) u_latch (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .load_in(latch_load),
        .load_idx_in(addr[4:0]),
        .load_data_in(data),
        .blank_in(latch_blank),
        .rd_idx_in(word_idx),
        .rd_data_out(latch_word)
    );

    // read data is captured in the setup cycle so it comes from a flop
    always_comb
    begin
        next_prdata = prdata_out;
        next_pslverr = pslverr_out;
        if (setup)
        begin
            next_prdata = 32'h0000_0000;
            next_pslverr = !hit_any;
            if (!pwrite_in && hit_addr)
                next_prdata[14:0] = addr;
            if (!pwrite_in && hit_data)
                next_prdata[13:0] = data;
            // error bit shows its flop while busy
            if (!pwrite_in && hit_ctrl)
                next_prdata[6:0] = {region, latch_only, erase_req, wr_err, program_enable,
                                    wr_bit, rd_bit};
            if (!pwrite_in && hit_stat)
                next_prdata[`FSWC_STAT_DONE] = done_flag;
        end
    end

    always_comb
    begin
        next_addr = addr;
        next_data = data;
        next_region = region;
        next_latch_only = latch_only;
        next_erase_req = erase_req;
        next_wr_err = wr_err;
        next_program_enable = program_enable;
        next_wr_bit = wr_bit;
        next_rd_bit = rd_bit;
        next_done_flag = done_flag;
        next_unlock_st = unlock_st;
        next_state = state;
        next_cnt = cnt;
        next_word_idx = word_idx;
        next_req = '{op: FOP_NONE, addr: 16'h0000, wdata: 14'h0000};
        latch_load = 1'b0;
        latch_blank = 1'b0;
        err_set = 1'b0;
        if (acc_wr && hit_addr)
            next_addr = pwdata_in[14:0];
        if (acc_wr && hit_data)
            next_data = pwdata_in[13:0];
        if (acc_wr && hit_ctrl)
        begin
            next_region = pwdata_in[`FSWC_CTRL_REGS];
            next_latch_only = pwdata_in[`FSWC_CTRL_LATCH_ONLY];
            next_program_enable = pwdata_in[`FSWC_CTRL_PROGRAM_ENABLE];
            next_wr_err = pwdata_in[`FSWC_CTRL_ERR];
            next_erase_req = erase_req || pwdata_in[`FSWC_CTRL_FREE];
        end
        if (acc_wr && hit_stat && pwdata_in[`FSWC_STAT_DONE])
            next_done_flag = 1'b0;
        // unlock key sequence
        // any transfer other than the expected next step breaks it
        if (acc_wr || acc_rd)
        begin
            unique case (unlock_st)
                UNL_IDLE:
                    if (acc_wr && hit_key && pwdata_in[7:0] == `FSWC_KEY_FIRST)
                        next_unlock_st = UNL_55;
                UNL_55:
                begin
                    next_unlock_st = UNL_IDLE;
                    if (acc_wr && hit_key && pwdata_in[7:0] == `FSWC_KEY_SECOND)
                        next_unlock_st = UNL_AA;
                    else
                        err_set = 1'b1;
                end
                UNL_AA:
                begin
                    next_unlock_st = UNL_IDLE;
                    if (!start_ok)
                        err_set = 1'b1;
                end
            endcase
        end
        if (start_ok)
        begin
            if (pwdata_in[`FSWC_CTRL_FREE] || erase_req)
            begin
                if (prot)
                    err_set = 1'b1;
                else if (pwdata_in[`FSWC_CTRL_PROGRAM_ENABLE])
                begin
                    next_wr_bit = 1'b1;
                    next_state = ST_ERASE_WAIT;
                    next_cnt = 24'(ERASE_CYCLES - 1);
                    // array sets the row to ones
                    next_req.op = FOP_ERASE;
                    next_req.addr = {pwdata_in[`FSWC_CTRL_REGS],
                                     addr[14:5], 5'b00000};
                end
            end
            else if (pwdata_in[`FSWC_CTRL_LATCH_ONLY])
                latch_load = 1'b1;
            else if (prot)
                err_set = 1'b1;
            else if (pwdata_in[`FSWC_CTRL_PROGRAM_ENABLE])
            begin
                next_wr_bit = 1'b1;
                next_state = ST_PROG_SEND;
                next_word_idx = 5'd0;
            end
        end
        else if (acc_wr && hit_ctrl && pwdata_in[`FSWC_CTRL_RD] &&
                 state == ST_IDLE)
        begin
            if (pwdata_in[`FSWC_CTRL_REGS] && !aux_readable(addr))
                next_data = `FSWC_DATA_RST;
            else
            begin
                next_rd_bit = 1'b1;
                next_state = ST_READ_WAIT;
                next_req.op = FOP_READ;
                next_req.addr = {pwdata_in[`FSWC_CTRL_REGS], addr};
            end
        end
        unique case (state)
            ST_IDLE:
                ;
            ST_READ_WAIT:
                next_state = ST_READ_CAP;
            ST_READ_CAP:
            begin
                next_data = flash_rdata_in;
                next_rd_bit = 1'b0;
                next_state = ST_IDLE;
            end
            ST_ERASE_WAIT:
            begin
                next_cnt = cnt - 24'd1;
                if (cnt == 24'd0)
                begin
                    next_wr_bit = 1'b0;
                    next_erase_req = 1'b0;
                    next_done_flag = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_PROG_SEND:
            begin
                next_req.op = FOP_PROG;
                next_req.addr = {region, addr[14:5], word_idx};
                next_req.wdata = latch_word;
                next_word_idx = word_idx + 5'd1;
                if (word_idx == 5'(ROW_WORDS - 1))
                begin
                    next_state = ST_PROG_WAIT;
                    next_cnt = 24'(PROG_CYCLES - 1);
                end
            end
            ST_PROG_WAIT:
            begin
                next_cnt = cnt - 24'd1;
                if (cnt == 24'd0)
                begin
                    latch_blank = 1'b1;
                    next_done_flag = 1'b1;
                    next_wr_bit = 1'b0;
                    next_state = ST_IDLE;
                end
            end
        endcase
        // hardware set only, wins over clear
        if (err_set)
            next_wr_err = 1'b1;
        if (dev_rst_in)
        begin
            next_wr_err = wr_err || wr_bit;
            next_addr = `FSWC_ADDR_RST;
            next_region = 1'b0;
            next_latch_only = 1'b0;
            next_erase_req = 1'b0;
            next_program_enable = 1'b0;
            next_wr_bit = 1'b0;
            next_rd_bit = 1'b0;
            next_done_flag = 1'b0;
            next_unlock_st = UNL_IDLE;
            next_state = ST_IDLE;
            next_req.op = FOP_NONE;
            latch_load = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            addr <= `FSWC_ADDR_RST;
            region <= 1'b0;
            latch_only <= 1'b0;
            erase_req <= 1'b0;
            wr_err <= 1'b0;
            program_enable <= 1'b0;
            wr_bit <= 1'b0;
            rd_bit <= 1'b0;
            done_flag <= 1'b0;
            unlock_st <= UNL_IDLE;
            state <= ST_IDLE;
            cnt <= 24'd0;
            word_idx <= 5'd0;
            flash_req_out <= '{op: FOP_NONE, addr: 16'h0000, wdata: 14'h0000};
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end
        else
        begin
            addr <= next_addr;
            region <= next_region;
            latch_only <= next_latch_only;
            erase_req <= next_erase_req;
            wr_err <= next_wr_err;
            program_enable <= next_program_enable;
            wr_bit <= next_wr_bit;
            rd_bit <= next_rd_bit;
            done_flag <= next_done_flag;
            unlock_st <= next_unlock_st;
            state <= next_state;
            cnt <= next_cnt;
            word_idx <= next_word_idx;
            flash_req_out <= next_req;
            prdata_out <= next_prdata;
            pslverr_out <= next_pslverr;
        end
    end

    // of the two resets, only power-on reset clears the data word
    always_ff @(posedge clk_sys_in)
    begin
        data <= sys_rst_in ? `FSWC_DATA_RST : next_data;
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in || dev_rst_in);

    property p_aux_write_only_ok;
        (flash_req_out.op inside {FOP_ERASE, FOP_PROG}) && flash_req_out.addr[15]
            |-> aux_writable({flash_req_out.addr[14:5], 5'b00000}) ||
                aux_writable(flash_req_out.addr[14:0]);
    endproperty
    a_aux_write_only_ok: assert property (p_aux_write_only_ok)
        else $error("array change in read-only aux area");

    property p_bad_read_zero;
        acc_wr && hit_ctrl && pwdata_in[`FSWC_CTRL_RD] && !start_try &&
        state == ST_IDLE && pwdata_in[`FSWC_CTRL_REGS] && !aux_readable(addr)
            |=> data == 14'h0000 && !rd_bit;
    endproperty
    a_bad_read_zero: assert property (p_bad_read_zero)
        else $error("invalid aux read did not clear data");

    property p_prot_error;
        start_ok && prot && !pwdata_in[`FSWC_CTRL_LATCH_ONLY] |=> wr_err && !wr_bit;
    endproperty
    a_prot_error: assert property (p_prot_error)
        else $error("protected start did not flag error");

    property p_err_sticky;
        wr_err && !(acc_wr && hit_ctrl) |=> wr_err;
    endproperty
    a_err_sticky: assert property (p_err_sticky)
        else $error("error flag cleared by hardware");

    property p_latch_no_array;
        latch_load |=> flash_req_out.op == FOP_NONE && !wr_bit;
    endproperty
    a_latch_no_array: assert property (p_latch_no_array)
        else $error("latch load touched the array");

    property p_prog_burst;
        $rose(wr_bit) && state == ST_PROG_SEND
            |-> (flash_req_out.op != FOP_PROG) ##1
                (flash_req_out.op == FOP_PROG) [*8];
    endproperty
    a_prog_burst: assert property (p_prog_burst)
        else $error("row program burst broken");

    property p_enable_needed;
        $rose(wr_bit) |-> $past(pwdata_in[`FSWC_CTRL_PROGRAM_ENABLE]);
    endproperty
    a_enable_needed: assert property (p_enable_needed)
        else $error("operation started without enable");

    property p_unlock_needed;
        $rose(wr_bit) |-> $past(unlock_st) == UNL_AA;
    endproperty
    a_unlock_needed: assert property (p_unlock_needed)
        else $error("write start without unlock");

    property p_read_ends;
        $rose(rd_bit) |-> ##[1:2] !rd_bit;
    endproperty
    a_read_ends: assert property (p_read_ends)
        else $error("read start not cleared");

    property p_done_on_end;
        $fell(wr_bit) && !$past(dev_rst_in) |-> done_flag;
    endproperty
    a_done_on_end: assert property (p_done_on_end)
        else $error("completion flag missing");

    c_erase: cover property (state == ST_ERASE_WAIT ##1 state == ST_IDLE);
    c_prog: cover property (state == ST_PROG_WAIT ##1 state == ST_IDLE);
    c_latch: cover property (latch_load);
    c_broken_unlock: cover property (unlock_st == UNL_55 && err_set);

endmodule : fswc_controller
`default_nettype wire

/* File: logic/fswc_defs.svh */
// offsets, field positions, reset values and timing counts of the
// flash self-write controller; assumes a 200 MHz system clock.
// Operation
// - aux user ids and config words writable
// - id words and info area read-only
// - invalid aux read clears data word
// - error on protection, reset, broken unlock; a reset sets it only while a write is busy
// - hardware never clears the error flag
// - error flag undefined while write busy
// - erase whole row, data ignored
// - erased row reads all ones
// - latch load ignores protection, no array
// - program row then blank all latches
// - no erase or program without enable
// - write start only after 55 then aa
// - self-timed, hardware clears write start
// - read start reads, then clears itself
// - 15-bit address, top bit undefined busy
// - data word survives non power-on resets
// - upper bits row, low five latch
// - completion flag set after erase/write
`ifndef FSWC_DEFS_SVH
`define FSWC_DEFS_SVH

// register indices; byte address is four times the index
`define FSWC_IDX_ADDR 14'h1c8c
`define FSWC_IDX_DATA 14'h1c8e
`define FSWC_IDX_CTRL 14'h1c90
`define FSWC_IDX_KEY 14'h1c91
`define FSWC_IDX_STAT 14'h1c92

`define FSWC_CTRL_RD 0
`define FSWC_CTRL_WR 1
`define FSWC_CTRL_PROGRAM_ENABLE 2
`define FSWC_CTRL_ERR 3
`define FSWC_CTRL_FREE 4
`define FSWC_CTRL_LATCH_ONLY 5
`define FSWC_CTRL_REGS 6
`define FSWC_STAT_DONE 0

`define FSWC_KEY_FIRST 8'h55
`define FSWC_KEY_SECOND 8'haa
`define FSWC_ADDR_RST 15'h0000
`define FSWC_DATA_RST 14'h0000
`define FSWC_LATCH_BLANK 14'h3fff

// aux region offsets, relative to the 0x8000 base
`define FSWC_UID_LO 15'h0000
`define FSWC_UID_HI 15'h0003
`define FSWC_DID_LO 15'h0005
`define FSWC_DID_HI 15'h0006
`define FSWC_CFG_LO 15'h0007
`define FSWC_CFG_HI 15'h000b
`define FSWC_DIA_LO 15'h0100
`define FSWC_DIA_HI 15'h02ff

`define FSWC_CLK_MHZ 200
`define FSWC_ERASE_TIME_US 2000
`define FSWC_PROG_TIME_US 2000

`endif

/* File: logic/fswc_pkg.sv */
// types shared by the flash self-write controller and its latch bank
// assumes fswc_defs.svh is included by the modules that need numbers
package fswc_pkg;

    typedef enum logic [1:0] {FOP_NONE, FOP_READ, FOP_ERASE, FOP_PROG} fswc_fop_e;

    typedef struct packed {
        fswc_fop_e op;
        logic [15:0] addr;
        logic [13:0] wdata;
    } fswc_flash_req_s;

    typedef enum {UNL_IDLE, UNL_55, UNL_AA} fswc_unlock_e;

    typedef enum {ST_IDLE, ST_READ_WAIT, ST_READ_CAP, ST_ERASE_WAIT,
                  ST_PROG_SEND, ST_PROG_WAIT} fswc_state_e;

endpackage : fswc_pkg

/* File: logic/fswc_latch_bank.sv */
// row write latches of the flash self-write controller
// assumes load and blank requests come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "fswc_defs.svh"

module fswc_latch_bank
    import fswc_pkg::*;
#(
    parameter int unsigned WORDS = 32,
    parameter int unsigned IDX_W = 5
)(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic load_in,
    input wire logic [IDX_W-1:0] load_idx_in,
    input wire logic [13:0] load_data_in,
    input wire logic blank_in,
    input wire logic [IDX_W-1:0] rd_idx_in,
    output logic [13:0] rd_data_out
);
    logic [13:0] latch [WORDS];
    logic [13:0] next_latch [WORDS];

    always_comb
    begin
        for (int i = 0; i < WORDS; i++)
        begin
            next_latch[i] = latch[i];
            // blank state after each row program
            if (blank_in)
                next_latch[i] = `FSWC_LATCH_BLANK;
            else if (load_in && load_idx_in == IDX_W'(i))
                next_latch[i] = load_data_in;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        for (int i = 0; i < WORDS; i++)
            latch[i] <= sys_rst_in ? `FSWC_LATCH_BLANK : next_latch[i];
    end

    assign rd_data_out = latch[rd_idx_in];

endmodule : fswc_latch_bank
`default_nettype wire

/* File: dv/fswc_flash_model.sv */
// flash array model behind the controller's request port
// assumes one request per cycle; reads answered the following cycle
`timescale 1ns/1ps
`default_nettype none
module fswc_flash_model
    import fswc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire fswc_flash_req_s req_in,
    output logic [13:0] rdata_out
);
    logic [13:0] mem [logic [15:0]];
    logic [13:0] cur;
    initial rdata_out = 14'h0;
    always @(posedge clk_sys_in)
    begin
        cur = mem.exists(req_in.addr) ? mem[req_in.addr] : 14'h3fff;
        // idle bus toggles so stale data is never trusted
        rdata_out <= ~rdata_out;
        if (req_in.op == FOP_READ)
            rdata_out <= cur;
        if (req_in.op == FOP_ERASE)
            for (int i = 0; i < 32; i++)
                mem[{req_in.addr[15:5], 5'(i)}] = 14'h3fff;
        if (req_in.op == FOP_PROG)
            mem[req_in.addr] = cur & req_in.wdata;
    end
endmodule : fswc_flash_model
`default_nettype wire

/* File: dv/flash_self_write_controller_test.sv */
// self-checking bench for the flash self-write controller
// assumes zero-wait apb slave and the flash model on the far side
`timescale 1ns/1ps
`default_nettype none
`include "fswc_defs.svh"
module flash_self_write_controller_test;
    import fswc_pkg::*;
    localparam logic [15:0] A_ADDR = {`FSWC_IDX_ADDR, 2'b00};
    localparam logic [15:0] A_DATA = {`FSWC_IDX_DATA, 2'b00};
    localparam logic [15:0] A_CTRL = {`FSWC_IDX_CTRL, 2'b00};
    localparam logic [15:0] A_KEY = {`FSWC_IDX_KEY, 2'b00};
    localparam logic [15:0] A_STAT = {`FSWC_IDX_STAT, 2'b00};
    logic clk_sys_in = 1'b0;
    logic sys_rst_in, dev_rst, psel, penable, pwrite, pready, pslverr;
    logic wp, busy;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [13:0] rdata;
    logic [13:0] d [4];
    logic [9:0] row;
    logic [63:0] e;
    logic [63:0] q [$];
    fswc_flash_req_s req;
    int bad_count = 0;
    int tests_run = 0;
    always #2.5 clk_sys_in = ~clk_sys_in;
    fswc_controller #(.ERASE_CYCLES(8), .PROG_CYCLES(8)) u_fswc_controller (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .dev_rst_in(dev_rst), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .write_protect_in(wp), .flash_rdata_in(rdata),
        .flash_req_out(req), .busy_out(busy));
    fswc_flash_model u_fswc_flash_model (.clk_sys_in(clk_sys_in),
        .req_in(req), .rdata_out(rdata));
    task automatic test_done;
        if (bad_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    task automatic fail(input string m);
        $display("ERROR %0t: %s", $time, m);
        bad_count++;
    endtask : fail
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] v);
        @(posedge clk_sys_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        do
            @(posedge clk_sys_in);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [15:0] a, input logic [31:0] x,
                      input logic [31:0] m);
        q.push_back({m, x & m});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic unlock(input logic [31:0] c);
        // key steps back to back, nothing between
        apb(1'b1, A_KEY, 32'h55);
        apb(1'b1, A_KEY, 32'haa);
        apb(1'b1, A_CTRL, c);
    endtask : unlock
    task automatic rdw(input logic [15:0] a, input logic rg,
                       input logic [13:0] x);
        apb(1'b1, A_ADDR, {16'h0, a});
        apb(1'b1, A_CTRL, {25'h0, rg, 6'h05});
        repeat (3) @(posedge clk_sys_in);
        rd(A_DATA, {18'h0, x}, 32'h3fff);
    endtask : rdw
    // bounded wait for a started erase or program to finish
    task automatic wait_idle;
        int seen;
        seen = 0;
        for (int k = 0; k < 200; k++)
        begin
            @(posedge clk_sys_in);
            if (busy === 1'b1)
                seen++;
            else if (seen > 0)
                break;
        end
        tests_run++;
        if (busy !== 1'b0 || seen == 0)
            fail("operation did not run and finish");
        rd(A_STAT, 32'h1, 32'h1);
        apb(1'b1, A_STAT, 32'h1);
        rd(A_STAT, 32'h0, 32'h1);
    endtask : wait_idle
    always @(posedge clk_sys_in)
    begin
        if (psel && penable && pready && !pwrite && q.size() > 0)
        begin
            e = q.pop_front();
            tests_run++;
            if ((prdata & e[63:32]) !== e[31:0])
                fail("read data mismatch");
            if (pslverr !== !(paddr inside {A_ADDR, A_DATA, A_CTRL,
                                            A_KEY, A_STAT}))
                fail("slave error mismatch");
        end
    end
    initial
    begin
        #150000;
        fail("watchdog expired");
        test_done();
    end
    initial
    begin
        {sys_rst_in, dev_rst, psel, penable, pwrite, wp} = 6'b100000;
        paddr = 16'h0;
        pwdata = 32'h0;
        void'($urandom(32'hca7fe936));
        repeat (10) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        rd(A_ADDR, 32'h0, 32'hffff);
        rd(A_CTRL, 32'h0, 32'hff);
        apb(1'b1, A_ADDR, 32'hffff);
        rd(A_ADDR, 32'h7fff, 32'hffff);
        rd(16'h7250, 32'h0, 32'hffffffff);
        apb(1'b1, A_KEY, 32'h55);
        // the flag is set at the breaking access, after its own setup
        rd(A_KEY, 32'h0, 32'hff);
        rd(A_CTRL, 32'h8, 32'h8);
        apb(1'b1, A_CTRL, 32'h0);
        rd(A_CTRL, 32'h0, 32'h8);
        row = 10'($urandom());
        apb(1'b1, A_ADDR, {17'h0, row, 5'h3});
        unlock(32'h16);
        wait_idle();
        rdw({1'b0, row, 5'h3}, 1'b0, 14'h3fff);
        for (int i = 0; i < 4; i++)
        begin
            d[i] = 14'($urandom());
            wp <= (i == 3);
            apb(1'b1, A_ADDR, {17'h0, row, 5'(i)});
            apb(1'b1, A_DATA, {18'h0, d[i]});
            unlock(32'h26);
            rd(A_CTRL, 32'h24, 32'h2e);
        end
        wp <= 1'b0;
        unlock(32'h06);
        wait_idle();
        for (int i = 0; i < 4; i++)
            rdw({1'b0, row, 5'(i)}, 1'b0, d[i]);
        rdw({1'b0, row, 5'h4}, 1'b0, 14'h3fff);
        apb(1'b1, A_ADDR, 32'h4);
        apb(1'b1, A_CTRL, 32'h41);
        rd(A_DATA, 32'h0, 32'h3fff);
        apb(1'b1, A_ADDR, 32'h105);
        unlock(32'h46);
        rd(A_CTRL, 32'h48, 32'h4a);
        apb(1'b1, A_CTRL, 32'h0);
        apb(1'b1, A_ADDR, 32'h1);
        apb(1'b1, A_DATA, {18'h0, d[1]});
        unlock(32'h66);
        unlock(32'h46);
        wait_idle();
        rdw(16'h1, 1'b1, d[1]);
        apb(1'b1, A_CTRL, 32'h6);
        rd(A_CTRL, 32'h4, 32'h0e);
        apb(1'b1, A_ADDR, {17'h0, row, 5'h0});
        wp <= 1'b1;
        unlock(32'h16);
        rd(A_CTRL, 32'h8, 32'h0a);
        wp <= 1'b0;
        apb(1'b1, A_CTRL, 32'h0);
        unlock(32'h12);
        rd(A_CTRL, 32'h0, 32'h0e);
        rd(A_STAT, 32'h0, 32'h1);
        unlock(32'h16);
        @(posedge clk_sys_in);
        dev_rst <= 1'b1;
        @(posedge clk_sys_in);
        dev_rst <= 1'b0;
        rd(A_CTRL, 32'h8, 32'h0a);
        rd(A_DATA, {18'h0, d[1]}, 32'h3fff);
        repeat (3) @(posedge clk_sys_in);
        test_done();
    end
endmodule : flash_self_write_controller_test
`default_nettype wire
